// file: rtl/pfc_regs.vh
// pfc_regs.vh - bus cycle constants for the parallel flash host controller
// assumes sys_clk at 250 MHz (4 ns period); included by bare name
`ifndef PFC_REGS_VH
`define PFC_REGS_VH

`define PFC_CLK_PERIOD_NS 4
// address setup before strobe, strobe width, data hold after strobe (ns)
`define PFC_T_SETUP_NS 10
`define PFC_T_STROBE_NS 70
`define PFC_T_HOLD_NS 20
// hardware reset low time and recovery before first access (ns)
`define PFC_T_RST_NS 500
`define PFC_T_RH_NS 200
// least times round up to whole cycles
`define PFC_CYC(ns) (((ns) + `PFC_CLK_PERIOD_NS - 1) / `PFC_CLK_PERIOD_NS)
`define PFC_SETUP_CYC `PFC_CYC(`PFC_T_SETUP_NS)
`define PFC_STROBE_CYC `PFC_CYC(`PFC_T_STROBE_NS)
`define PFC_HOLD_CYC `PFC_CYC(`PFC_T_HOLD_NS)
`define PFC_RST_CYC `PFC_CYC(`PFC_T_RST_NS)
`define PFC_RH_CYC `PFC_CYC(`PFC_T_RH_NS)
// protect cycle address pattern: bit 6 selects unprotect, low bits 3..0 = 4'b0010
`define PFC_PROT_A6 6
`define PFC_PROT_LOW 4'h2
// sector address lowest bit
`define PFC_SECT_LSB 12

`endif

// file: rtl/pfc_timer.v
// pfc_timer.v - down counter for bus cycle phases
// assumes one clock; load pulses one cycle, done is a one-cycle pulse
`timescale 1ns/1ps
module pfc_timer #(
    parameter W = 8
) (
    // clock and reset
    input wire sys_clk,
    input wire arst_n,
    // control
    input wire load,
    input wire [W-1:0] count,
    output reg done
);
    reg [W-1:0] cnt_r;
    reg busy_r;

    // counts load value cycles then pulses done once
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_r <= {W{1'b0}};
            busy_r <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (load) begin
                cnt_r <= count;
                busy_r <= 1'b1;
            end else if (busy_r) begin
                if (cnt_r <= {{(W-1){1'b0}}, 1'b1}) begin
                    busy_r <= 1'b0;
                    done <= 1'b1;
                end else begin
                    cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule

// file: rtl/pfc_host.v
// pfc_host.v - host controller driving a clockless parallel nor flash by its pins
// assumes flash pins are synchronous to sys_clk and the board resolves the data bus
//
// Functional notes
// R01 - read: select, gate low, strobe high
// R02 - write: select, strobe low, gate high
// R03 - command register latched by device only
// R04 - device floats data while gate high
// R05 - reset low aborts and floats device
// R06 - width high: sixteen data pins used
// R07 - width low: top pin is byte address
// R08 - address span depends on width mode
// R09 - device reads array after reset
// R10 - array read until command changes it
// R11 - bypass program takes two writes
// R12 - width select sets program data size
// R13 - erase targets sector bits above twelve
// R14 - identification codes on low eight pins
// R15 - protect: elevated reset, wp high, pattern
// R16 - unprotect: same, address bit six high
// R17 - wp low keeps outer sector protected
// R18 - wp high follows last protect operation
// R19 - wp pulled up inside device
// R20 - deselected device floats and ignores strobes
`timescale 1ns/1ps
`include "pfc_regs.vh"
module pfc_host #(
    parameter AW = 20,
    parameter RST_CYC = `PFC_RST_CYC
) (
    // clock and reset
    input wire sys_clk,
    input wire arst_n,
    // user request
    input wire req_valid,
    input wire [2:0] req_op,
    input wire [AW-1:0] req_addr,
    input wire [15:0] req_wdata,
    input wire req_byte,
    input wire req_wp,
    output reg req_ready,
    output reg rsp_valid,
    output reg [15:0] rsp_rdata,
    // flash pins
    output reg [AW-1:0] fl_addr,
    output reg [15:0] fl_dq_o,
    output reg [15:0] fl_dq_oe,
    input wire [15:0] fl_dq_i,
    output reg fl_ce_n,
    output reg fl_oe_n,
    output reg fl_we_n,
    output reg fl_rst_n,
    output reg fl_rst_hv,
    output reg fl_byte_n,
    output reg fl_wp_n
);
    // user operations
    localparam OP_READ = 3'h0;
    localparam OP_WRITE = 3'h1;
    localparam OP_RESET = 3'h2;
    localparam OP_PROT = 3'h3;
    localparam OP_UNPROT = 3'h4;
    // one-hot states
    localparam S_IDLE = 6'h01;
    localparam S_SETUP = 6'h02;
    localparam S_STROBE = 6'h04;
    localparam S_HOLD = 6'h08;
    localparam S_RST = 6'h10;
    localparam S_RH = 6'h20;
    // phase loads; counts are small, so the cut to the timer width drops only zeros
    localparam [31:0] SETUP_LD = `PFC_SETUP_CYC;
    localparam [31:0] STROBE_LD = `PFC_STROBE_CYC;
    localparam [31:0] HOLD_LD = `PFC_HOLD_CYC;
    localparam [31:0] RH_LD = `PFC_RH_CYC;
    localparam [31:0] RST_LD = RST_CYC;

    // sequencer state and timer handshake
    reg [5:0] state_r;
    reg [2:0] op_r;
    reg tload;
    reg [15:0] tcount;
    wire tdone;

    // one timer serves every phase, loaded one cycle after the state moves
    pfc_timer #(.W(16)) u_timer (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .load(tload),
        .count(tcount),
        .done(tdone)
    );

    // latched op: anything but a read or a reset strobes the write line
    wire is_wr = (op_r != OP_READ);
    // codes above unprotect are not ours; they must never reach the pins as a write
    wire op_known = (req_op <= OP_UNPROT);
    // both protect kinds share the elevated reset cycle
    wire is_prot = (req_op == OP_PROT) || (req_op == OP_UNPROT);
    // protect pattern: bit 6 chooses unprotect, bits 3..0 fixed
    wire [AW-1:0] prot_addr = {req_addr[AW-1:`PFC_SECT_LSB], {(`PFC_SECT_LSB-7){1'b0}},
        (req_op == OP_UNPROT), 2'b00, `PFC_PROT_LOW};

    // sequencer; outputs all registered
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= S_IDLE;
            op_r <= OP_READ;
            tload <= 1'b0;
            tcount <= 16'h0000;
            req_ready <= 1'b1;
            rsp_valid <= 1'b0;
            rsp_rdata <= 16'h0000;
            fl_addr <= {AW{1'b0}};
            fl_dq_o <= 16'h0000;
            fl_dq_oe <= 16'h0000;
            fl_ce_n <= 1'b1; // R20
            fl_oe_n <= 1'b1;
            fl_we_n <= 1'b1;
            fl_rst_n <= 1'b1;
            fl_rst_hv <= 1'b0;
            fl_byte_n <= 1'b1;
            fl_wp_n <= 1'b1; // R19
        end else begin
            tload <= 1'b0;
            rsp_valid <= 1'b0;
            case (state_r)
                S_IDLE: begin
                    // unknown code: answer at once and stay idle, no bus cycle
                    if (req_valid && req_ready && !op_known) begin
                        rsp_valid <= 1'b1;
                    end else if (req_valid && req_ready) begin
                        req_ready <= 1'b0;
                        op_r <= req_op;
                        fl_byte_n <= ~req_byte; // R06 R07 R12
                        fl_wp_n <= ~req_wp; // R17 R18
                        tload <= 1'b1;
                        if (req_op == OP_RESET) begin
                            fl_rst_n <= 1'b0; // R05 R09
                            tcount <= RST_LD[15:0];
                            state_r <= S_RST;
                        end else begin
                            // byte mode: address bit 0 rides on top data pin
                            fl_addr <= is_prot ? prot_addr :
                                (req_byte ? (req_addr >> 1) : req_addr); // R08 R13
                            if (is_prot) begin
                                fl_rst_hv <= 1'b1; // R15 R16
                                fl_wp_n <= 1'b1; // R15
                            end
                            fl_ce_n <= 1'b0;
                            tcount <= SETUP_LD[15:0];
                            state_r <= S_SETUP;
                            if (req_op == OP_READ) begin
                                // top pin drives byte lsb, rest floats so device can drive
                                fl_dq_oe <= req_byte ? 16'h8000 : 16'h0000; // R07
                                fl_dq_o <= {req_addr[0], 15'h0000};
                            end else begin
                                fl_dq_oe <= req_byte ? 16'h80FF : 16'hFFFF; // R12
                                fl_dq_o <= req_byte ? {req_addr[0], 7'h00, req_wdata[7:0]} : req_wdata;
                            end
                        end
                    end
                end
                // address and select settle before any strobe
                S_SETUP: begin
                    if (tdone) begin
                        // gate and strobe never low together
                        if (is_wr)
                            fl_we_n <= 1'b0; // R02 R11
                        else
                            fl_oe_n <= 1'b0; // R01 R10 R14
                        tload <= 1'b1;
                        tcount <= STROBE_LD[15:0];
                        state_r <= S_STROBE;
                    end
                end
                // read data is taken on the last strobe cycle, before the gate rises
                S_STROBE: begin
                    if (tdone) begin
                        if (!is_wr)
                            rsp_rdata <= fl_byte_n ? fl_dq_i : {8'h00, fl_dq_i[7:0]}; // R06 R14
                        fl_we_n <= 1'b1; // R03
                        fl_oe_n <= 1'b1; // R04
                        tload <= 1'b1;
                        tcount <= HOLD_LD[15:0];
                        state_r <= S_HOLD;
                    end
                end
                // data and address held past the strobe, then the bus is released
                S_HOLD: begin
                    if (tdone) begin
                        fl_ce_n <= 1'b1; // R20
                        fl_dq_oe <= 16'h0000;
                        fl_rst_hv <= 1'b0;
                        rsp_valid <= 1'b1;
                        req_ready <= 1'b1;
                        state_r <= S_IDLE;
                    end
                end
                // reset pin held low for the whole pulse
                S_RST: begin
                    if (tdone) begin
                        fl_rst_n <= 1'b1;
                        tload <= 1'b1;
                        tcount <= RH_LD[15:0];
                        state_r <= S_RH;
                    end
                end
                // recovery: no select until the flash can answer again
                S_RH: begin
                    if (tdone) begin
                        rsp_valid <= 1'b1;
                        req_ready <= 1'b1;
                        state_r <= S_IDLE;
                    end
                end
                default: begin
                    state_r <= S_IDLE;
                end
            endcase
        end
    end
endmodule

// file: verif/pfc_host_sva.sv
// pfc_host_sva.sv - pin protocol checker for pfc_host
// assumes it is bound onto pfc_host and sees only its ports
`timescale 1ns/1ps
module pfc_host_sva #(
    parameter AW = 20
) (
    // clock and reset
    input wire sys_clk,
    input wire arst_n,
    // flash pins
    input wire [AW-1:0] fl_addr,
    input wire [15:0] fl_dq_oe,
    input wire fl_ce_n,
    input wire fl_oe_n,
    input wire fl_we_n,
    input wire fl_rst_n,
    input wire fl_rst_hv,
    input wire fl_byte_n,
    input wire fl_wp_n
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    // gate low only on a selected read, host off the shared lanes
    property p_rd; !fl_oe_n |-> !fl_ce_n && fl_we_n && fl_rst_n && fl_dq_oe[14:0] == 15'h0; endproperty
    a_rd: assert property (p_rd) else $error("gate low outside a read");
    // a strobe opens only while selected with gate high, and lasts
    property p_wr; $fell(fl_we_n) |-> (!fl_ce_n && fl_oe_n) ##1 !fl_we_n [*8]; endproperty
    a_wr: assert property (p_wr) else $error("bad write strobe");
    // the device latches data at strobe end, so the low eight lanes are driven throughout
    property p_wd; !fl_we_n |-> fl_dq_oe[7:0] == 8'hFF; endproperty
    a_wd: assert property (p_wd) else $error("data not driven in strobe");
    // protect pattern on the low address bits, write protect released
    property p_pt; fl_rst_hv && !fl_we_n |-> fl_wp_n && fl_addr[5:0] == 6'h02; endproperty
    a_pt: assert property (p_pt) else $error("bad protect pattern");
    // elevated level and address steady for eight cycles after a protect strobe opens
    property p_hv; fl_rst_hv && $fell(fl_we_n) |=> (fl_rst_hv && $stable(fl_addr)) [*8]; endproperty
    a_hv: assert property (p_hv) else $error("protect cycle unstable");
    // nothing selected, strobed or driven while the flash is held in reset
    property p_rs; !fl_rst_n |-> fl_ce_n && fl_oe_n && fl_we_n && fl_dq_oe == 16'h0000; endproperty
    a_rs: assert property (p_rs) else $error("bus active during flash reset");
    // byte read: only the top pin is driven, carrying the byte select
    property p_by; !fl_oe_n && !fl_byte_n |-> fl_dq_oe == 16'h8000; endproperty
    a_by: assert property (p_by) else $error("byte read lanes wrong");
endmodule

// file: verif/pfc_flash_model.sv
// pfc_flash_model.sv - clockless nor flash model, sixteen words deep
// assumes the bench resolves the data bus; dq15 is fed back as byte address
`timescale 1ns/1ps
module pfc_flash_model #(
    parameter AW = 20,
    parameter [15:0] ID_CODE = 16'h005A // arbitrary value
) (
    // host pins
    input wire [AW-1:0] addr,
    input wire [15:0] dq_in,
    input wire ce_n,
    input wire oe_n,
    input wire we_n,
    input wire rst_n,
    input wire rst_hv,
    input wire byte_n,
    input wire wp_n,
    // data drive
    output logic [15:0] dq_out,
    output logic [15:0] dq_en
);
    logic [15:0] mem [0:15];
    logic [1:0] mode_r = 2'h0; // 0 array, 1 id, 2 bypass, 3 armed
    logic prot_r = 1'b0;
    wire live = rst_n || rst_hv;
    wire outer = &addr[AW-1:12];
    wire lock = outer && (wp_n === 1'b0 || prot_r); // floating pin reads high
    wire [15:0] wd = mem[addr[3:0]];
    wire [7:0] cmd = dq_in[7:0];
    initial begin
        for (int i = 0; i < 16; i++) begin
            mem[i] = {i[3:0], ~i[3:0], i[3:0], 4'h7};
        end
    end
    // command latches close on the rising strobe; reset wins over everything
    always @(posedge we_n or negedge live) begin
        if (!live) begin
            mode_r <= 2'h0;
        end else if (!ce_n && oe_n) begin
            if (rst_hv) begin
                prot_r <= outer ? !addr[6] : prot_r;
            end else if (mode_r == 2'h3) begin
                if (!lock) mem[addr[3:0]] <= wd & (byte_n ? dq_in : dq_in[15] ? {cmd, 8'hFF} : {8'hFF, cmd});
                mode_r <= 2'h2;
            end else begin
                mode_r <= cmd == 8'h90 ? 2'h1 : cmd == 8'h20 ? 2'h2 : cmd == 8'hF0 ? 2'h0 :
                    (cmd == 8'hA0 && mode_r == 2'h2) ? 2'h3 : mode_r;
            end
        end
    end
    // drive only on a selected read; a floating lane is not held
    always_comb begin
        dq_en = 16'h0000;
        dq_out = mode_r == 2'h1 ? ID_CODE : wd;
        if (!ce_n && !oe_n && we_n && rst_n) begin
            dq_en = byte_n ? 16'hFFFF : 16'h00FF;
            dq_out = byte_n ? dq_out : {8'h00, dq_in[15] ? wd[15:8] : wd[7:0]};
        end
    end
endmodule

// file: verif/testbench.sv
// testbench.sv - drives pfc_host against the flash model, checks read data
// assumes the design files and the flash model are compiled first
`timescale 1ns/1ps
module testbench;
    localparam [16:0] C = 17'h10000;
    logic sys_clk = 1'b0, arst_n = 1'b0, req_valid = 1'b0, req_byte = 1'b0, req_wp = 1'b0;
    logic [2:0] req_op = 3'h0;
    logic [19:0] req_addr = 20'h00000;
    logic [15:0] req_wdata = 16'h0000, w, junk = 16'h5A5A, m_out, m_en;
    logic [31:0] r, seed = 32'h00000046;
    logic [16:0] note, exp_q [$];
    int fail_count = 0, total_checks = 0;
    wire req_ready, rsp_valid, fl_ce_n, fl_oe_n, fl_we_n, fl_rst_n, fl_rst_hv, fl_byte_n, fl_wp_n;
    wire [15:0] rsp_rdata, fl_dq_o, fl_dq_oe;
    wire [19:0] fl_addr;
    // undriven lanes show a pattern that flips every cycle
    wire [15:0] fl_dq_i = (fl_dq_oe & fl_dq_o) | (~fl_dq_oe & m_en & m_out) | (~fl_dq_oe & ~m_en & junk);
    pfc_host #(.AW(20), .RST_CYC(4)) pfc_host_i (.sys_clk(sys_clk), .arst_n(arst_n), .req_valid(req_valid),
        .req_op(req_op), .req_addr(req_addr), .req_wdata(req_wdata), .req_byte(req_byte), .req_wp(req_wp),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .fl_addr(fl_addr),
        .fl_dq_o(fl_dq_o), .fl_dq_oe(fl_dq_oe), .fl_dq_i(fl_dq_i), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n),
        .fl_we_n(fl_we_n), .fl_rst_n(fl_rst_n), .fl_rst_hv(fl_rst_hv), .fl_byte_n(fl_byte_n), .fl_wp_n(fl_wp_n));
    pfc_flash_model pfc_flash_model_i (.addr(fl_addr), .dq_in(fl_dq_i), .ce_n(fl_ce_n), .oe_n(fl_oe_n),
        .we_n(fl_we_n), .rst_n(fl_rst_n), .rst_hv(fl_rst_hv), .byte_n(fl_byte_n), .wp_n(fl_wp_n),
        .dq_out(m_out), .dq_en(m_en));
    always #2 sys_clk = ~sys_clk;
    always @(posedge sys_clk) junk <= ~junk;
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    function automatic [15:0] pat(input [3:0] i);
        pat = {i, ~i, i, 4'h7};
    endfunction
    // xorshift source for the random read addresses and widths
    function automatic [31:0] xs(input [31:0] s);
        reg [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        xs = t ^ (t << 5);
    endfunction
    // one request held from a falling edge past the rising edge that takes it
    task automatic op(input [2:0] o, input [19:0] a, input [15:0] d, input [16:0] e);
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 500) begin
            @(negedge sys_clk);
            n++;
        end
        // a hung block counts once per request and the run still reaches the report
        if (req_ready !== 1'b1) begin
            fail_count++;
        end else begin
            exp_q.push_back(e);
            {req_op, req_addr, req_wdata, req_valid} = {o, a, d, 1'b1};
            @(negedge sys_clk);
            req_valid = 1'b0;
            @(negedge sys_clk);
        end
    endtask
    // oldest note answers each completed operation
    always @(negedge sys_clk) begin
        if (rsp_valid === 1'b1 && exp_q.size() > 0) begin
            note = exp_q.pop_front();
            if (note[16]) total_checks++;
            if (note[16] && rsp_rdata !== note[15:0]) begin
                fail_count++;
                $display("[ERR] %0t got %h exp %h", $time, rsp_rdata, note[15:0]);
            end
        end
    end
    initial begin
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk);
        arst_n = 1'b1;
        @(negedge sys_clk);
        for (int k = 0; k < 10; k++) begin
            seed = xs(seed);
            r = seed;
            req_byte = r[20];
            w = r[20] ? pat(r[4:1]) : pat(r[3:0]);
            op(3'h0, r[19:0], 16'h0000, C | (r[20] ? {8'h00, r[0] ? w[15:8] : w[7:0]} : w));
        end
        req_byte = 1'b0;
        op(3'h1, 20'h00555, 16'h0090, 17'h0);
        op(3'h0, 20'h00000, 16'h0000, C | 17'h0005A);
        op(3'h1, 20'h00000, 16'h00F0, 17'h0);
        op(3'h0, 20'h00002, 16'h0000, C | pat(2));
        op(3'h1, 20'h00555, 16'h0090, 17'h0);
        op(3'h2, 20'h00000, 16'h0000, 17'h0);
        op(3'h0, 20'h00004, 16'h0000, C | pat(4));
        op(3'h1, 20'h00000, 16'h0020, 17'h0);
        op(3'h1, 20'h00000, 16'h00A0, 17'h0);
        op(3'h1, 20'h00005, 16'h0F0F, 17'h0);
        op(3'h0, 20'h00005, 16'h0000, C | (pat(5) & 16'h0F0F));
        req_byte = 1'b1;
        op(3'h1, 20'h00000, 16'h00A0, 17'h0);
        op(3'h1, 20'h00017, 16'h003C, 17'h0);
        op(3'h0, 20'h00017, 16'h0000, C | ((pat(11) >> 8) & 16'h003C));
        req_byte = 1'b0;
        op(3'h3, 20'hFF000, 16'h0000, 17'h0);
        op(3'h1, 20'h00000, 16'h00A0, 17'h0);
        op(3'h1, 20'hFF009, 16'h0000, 17'h0);
        op(3'h0, 20'hFF009, 16'h0000, C | pat(9));
        op(3'h4, 20'hFF000, 16'h0000, 17'h0);
        req_wp = 1'b1;
        op(3'h1, 20'h00000, 16'h00A0, 17'h0);
        op(3'h1, 20'hFF009, 16'h0000, 17'h0);
        op(3'h0, 20'hFF009, 16'h0000, C | pat(9));
        req_wp = 1'b0;
        op(3'h1, 20'h00000, 16'h00A0, 17'h0);
        op(3'h1, 20'hFF009, 16'h00FF, 17'h0);
        op(3'h0, 20'hFF009, 16'h0000, C | (pat(9) & 16'h00FF));
        op(3'h1, 20'h00000, 16'h00A0, 17'h0);
        op(3'h7, 20'h00002, 16'h0000, 17'h0);
        op(3'h0, 20'h00002, 16'h0000, C | pat(2));
        for (int n = 0; n < 500 && exp_q.size() > 0; n++) @(negedge sys_clk);
        if (exp_q.size() > 0) fail_count++;
        finish_test();
    end
endmodule
bind pfc_host pfc_host_sva #(.AW(AW)) pfc_host_sva_i (.sys_clk(sys_clk), .arst_n(arst_n), .fl_addr(fl_addr),
    .fl_dq_oe(fl_dq_oe), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n), .fl_rst_n(fl_rst_n),
    .fl_rst_hv(fl_rst_hv), .fl_byte_n(fl_byte_n), .fl_wp_n(fl_wp_n));
